/* File: rtl/serial_regs_pkg.sv */
// Purpose: Shared constants for the serial port register block.
// Assumes: Registers sit at word index N, byte address 4*N, on APB.
// Notes:   Field positions are bit numbers inside each 8-bit register.
package serial_regs_pkg;
    // Register word indices
    localparam logic [7:0] IDX_CONTROL_ONE   = 8'h1a;
    localparam logic [7:0] IDX_CONTROL_TWO   = 8'h1b;
    localparam logic [7:0] IDX_BAUD_DIVISOR  = 8'h1c;
    localparam logic [7:0] IDX_LINE_STATUS   = 8'h1d;
    localparam logic [7:0] IDX_DATA_BUFFER   = 8'h1e;
    localparam logic [7:0] IDX_POWER_OFF     = 8'h1f;
    // Control one fields
    localparam int CR1_TX_EN       = 7;
    localparam int CR1_RX_EN       = 6;
    localparam int CR1_TX_STOP     = 5;
    localparam int CR1_PAR_EVEN    = 4;
    localparam int CR1_PAR_EN      = 3;
    localparam int CR1_IR_SEL      = 2;
    localparam int CR1_BASE_SEL    = 1;
    // Control two fields
    localparam int CR2_RT_LSB      = 3;
    localparam int CR2_NOISE_LSB   = 1;
    localparam int CR2_RX_STOP     = 0;
    // Line status fields
    localparam int SR_PARITY_ERR   = 7;
    localparam int SR_FRAME_ERR    = 6;
    localparam int SR_OVERRUN      = 5;
    localparam int SR_RX_BUSY      = 3;
    localparam int SR_RX_FULL      = 2;
    localparam int SR_TX_BUSY      = 1;
    localparam int SR_TX_FULL      = 0;
    // Power off control field
    localparam int POFF_GATE       = 0;
    // Reset values
    localparam logic [7:0] RST_CONTROL_ONE  = 8'h00;
    localparam logic [7:0] RST_CONTROL_TWO  = 8'h00;
    localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;
    localparam logic [7:0] RST_DATA_BUFFER  = 8'h00;
    localparam logic       RST_GATE         = 1'b0;
    // Readable masks
    localparam logic [7:0] CR1_READ_MASK    = 8'hfe;
    localparam logic [7:0] CR2_READ_MASK    = 8'h3f;
endpackage

/* File: rtl/pin_sync3.sv */
// Purpose: Three-stage synchroniser with agreement filter for one pin.
// Assumes: Input is asynchronous to sys_clk_i.
// Notes:   Output changes only once stages two and three agree.
`timescale 1ns/10ps
module pin_sync3 (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    // Pin and filtered level
    input  wire logic pin_i,
    output logic      level_o
);
    // Shift stages and filtered level
    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // Next state: shift, then follow stage three once two agree
    always_comb begin
        s_nxt       = s_r;
        s_nxt.stage = {s_r.stage[1:0], pin_i};
        if (s_r.stage[1] == s_r.stage[2]) begin
            s_nxt.level = s_r.stage[2];
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level_o = s_r.level;
endmodule

/* File: rtl/serial_port_regs.sv */
// Purpose: APB register side of a serial port: divisor, status, buffers.
// Assumes: A framing engine on sys_clk_i reports frame events.
// Notes:   Low-power entry is the rising edge of low_power_i.
// Behaviour
// - Timer clock source ignores divisor value
// - Low power keeps divisor value intact
// - Status read-only, resets zero, bit4 zero
// - Parity, framing, overrun error flags bits 7-5
// - Receive busy bit 3 during frame reception
// - Receive full bit 2 while data unread
// - Transmit busy bit 1 during frame transmission
// - Transmit full bit 0 after buffer write
// - Transmit full clears after interrupt, sets on write
// - Low power clears every status bit
// - Receive and transmit buffers share one address
// - Receive buffer undefined after low power entry
// - Transmit buffer undefined after low power entry
// - Clock gate zero stops port, one runs
// - Clock gate resets zero, set before use
// - Protected bits keep value when locked
// - Transmit stop, infrared select need transmit idle
// - Parity, base clock, count select need all idle
// - Noise time, receive stop need receive idle
// - Low power clears enables, keeps other control
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module serial_port_regs
    import serial_regs_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Power management and timer clock pin
    input  wire logic        low_power_i,
    input  wire logic        timer_output_clock_i,
    // Receive engine events
    input  wire logic        rx_start_i,
    input  wire logic        rx_done_i,
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        rx_parity_err_i,
    input  wire logic        rx_frame_err_i,
    // Transmit engine handshake
    input  wire logic        tx_done_i,
    output logic             tx_load_o,
    output logic      [7:0]  tx_data_o,
    output logic             transmit_interrupt_request_o,
    // Engine configuration and clocking
    output logic             port_clock_enable_o,
    output logic             base_tick_o,
    output logic             tx_enable_o,
    output logic             rx_enable_o,
    output logic             tx_two_stop_o,
    output logic             parity_even_o,
    output logic             parity_enable_o,
    output logic             ir_select_o,
    output logic      [2:0]  rt_select_o,
    output logic      [1:0]  noise_select_o,
    output logic             rx_two_stop_o
);
    import serial_regs_pkg::*;

    // Whole block state
    typedef struct packed {
        logic [7:0]  ctl_one;     // Control one
        logic [7:0]  ctl_two;     // Control two
        logic [7:0]  divisor;     // Baud divisor
        logic        gate;        // Serial clock gate
        logic        parity_error_flag;        // Parity error flag
        logic        framing_error_flag;        // Framing error flag
        logic        overrun_flag;        // Overrun flag
        logic        rbsy;        // Receive busy
        logic        receive_full_flag;        // Receive full flag
        logic        tbsy;        // Transmit busy
        logic        transmit_full_flag;        // Transmit full flag
        logic [7:0]  rx_buf;      // Receive data buffer
        logic [7:0]  tx_buf;      // Transmit data buffer
        logic [7:0]  tx_dat;      // Byte handed to engine
        logic        tx_load;     // Load pulse to engine
        logic        irq;         // Transmit interrupt pulse
        logic [7:0]  cnt;         // Divider count
        logic        tick;        // Base tick pulse
        logic        tmr_prev;    // Timer level delay
        logic        lp_prev;     // Low power delay
        logic [31:0] rdata;       // Captured read data
    } regs_state_t;

    regs_state_t s_r;
    regs_state_t s_nxt;

    // Bus decode and helpers
    logic       setup;            // APB setup phase
    logic       access;           // APB access phase
    logic       bus_wr;           // Write taking effect
    logic       bus_rd;           // Read taking effect
    logic [7:0] idx;              // Word index
    logic       hit;              // Mapped address
    logic       tmr_level;        // Filtered timer level
    logic       tmr_rise;         // Timer rising edge
    logic       lp_entry;         // Low power entry pulse
    logic       port_on;          // Port clock running
    logic       tx_unlock;        // Transmit side idle
    logic       rx_unlock;        // Receive side idle
    logic       all_unlock;       // Both sides idle
    logic       cfg_wr;           // Write to serial registers

    // Pack status byte; bit 4 always zero
    function automatic logic [7:0] pack_status(input regs_state_t st);
        logic [7:0] v;
        v                = 8'h00;
        v[SR_PARITY_ERR] = st.parity_error_flag;
        v[SR_FRAME_ERR]  = st.framing_error_flag;
        v[SR_OVERRUN]    = st.overrun_flag;
        v[SR_RX_BUSY]    = st.rbsy;
        v[SR_RX_FULL]    = st.receive_full_flag;
        v[SR_TX_BUSY]    = st.tbsy;
        v[SR_TX_FULL]    = st.transmit_full_flag;
        return v;
    endfunction

    // Timer clock pin synchroniser
    pin_sync3 u_tmr_sync (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .pin_i     (timer_output_clock_i),
        .level_o   (tmr_level)
    );

    // Decode and lock conditions
    assign setup      = psel_i & ~penable_i;
    assign access     = psel_i & penable_i;
    assign idx        = paddr_i[9:2];
    assign hit        = (paddr_i[31:10] == 22'h000000) && (paddr_i[1:0] == 2'h0)
                        && (idx >= IDX_CONTROL_ONE) && (idx <= IDX_POWER_OFF);
    assign bus_wr     = access & pwrite_i & hit;
    assign bus_rd     = access & ~pwrite_i & hit;
    assign tmr_rise   = tmr_level & ~s_r.tmr_prev;
    assign lp_entry   = low_power_i & ~s_r.lp_prev;
    assign port_on    = s_r.gate & ~low_power_i;
    assign cfg_wr     = bus_wr & port_on;
    assign tx_unlock  = ~s_r.ctl_one[CR1_TX_EN] & ~s_r.tbsy;
    assign rx_unlock  = ~s_r.ctl_one[CR1_RX_EN] & ~s_r.rbsy;
    assign all_unlock = tx_unlock & rx_unlock;

    // Next state: bus, events, divider, low-power entry
    always_comb begin
        s_nxt         = s_r;
        s_nxt.tx_load = 1'b0;
        s_nxt.irq     = 1'b0;
        s_nxt.tick    = 1'b0;
        s_nxt.tmr_prev = tmr_level;
        s_nxt.lp_prev = low_power_i;
        // Read data captured in setup phase
        if (setup) begin
            if (idx == IDX_CONTROL_ONE) begin
                s_nxt.rdata = {24'h000000, s_r.ctl_one & CR1_READ_MASK};
            end else if (idx == IDX_CONTROL_TWO) begin
                s_nxt.rdata = {24'h000000, s_r.ctl_two & CR2_READ_MASK};
            end else if (idx == IDX_BAUD_DIVISOR) begin
                s_nxt.rdata = {24'h000000, s_r.divisor};
            end else if (idx == IDX_LINE_STATUS) begin
                s_nxt.rdata = {24'h000000, pack_status(s_r)};
            end else if (idx == IDX_DATA_BUFFER) begin
                s_nxt.rdata = {24'h000000, s_r.rx_buf};
            end else if (idx == IDX_POWER_OFF) begin
                s_nxt.rdata = {31'h00000000, s_r.gate};
            end else begin
                s_nxt.rdata = 32'h00000000;
            end
        end
        // Gate write always allowed
        if (bus_wr && idx == IDX_POWER_OFF) begin
            s_nxt.gate = pwdata_i[POFF_GATE];
        end
        // Serial register writes need running clock
        if (cfg_wr) begin
            if (idx == IDX_CONTROL_ONE) begin
                s_nxt.ctl_one[CR1_TX_EN] = pwdata_i[CR1_TX_EN];
                s_nxt.ctl_one[CR1_RX_EN] = pwdata_i[CR1_RX_EN];
                // Dropping transmit enable discards buffer
                if (s_r.ctl_one[CR1_TX_EN] && !pwdata_i[CR1_TX_EN]) begin
                    s_nxt.transmit_full_flag = 1'b0;
                end
                if (tx_unlock) begin
                    s_nxt.ctl_one[CR1_TX_STOP] = pwdata_i[CR1_TX_STOP];
                    s_nxt.ctl_one[CR1_IR_SEL]  = pwdata_i[CR1_IR_SEL];
                end
                if (all_unlock) begin
                    s_nxt.ctl_one[CR1_PAR_EVEN] = pwdata_i[CR1_PAR_EVEN];
                    s_nxt.ctl_one[CR1_PAR_EN]   = pwdata_i[CR1_PAR_EN];
                    s_nxt.ctl_one[CR1_BASE_SEL] = pwdata_i[CR1_BASE_SEL];
                end
            end else if (idx == IDX_CONTROL_TWO) begin
                if (all_unlock) begin
                    s_nxt.ctl_two[CR2_RT_LSB+:3] = pwdata_i[CR2_RT_LSB+:3];
                end
                if (rx_unlock) begin
                    s_nxt.ctl_two[CR2_NOISE_LSB+:2] = pwdata_i[CR2_NOISE_LSB+:2];
                    s_nxt.ctl_two[CR2_RX_STOP]      = pwdata_i[CR2_RX_STOP];
                end
            end else if (idx == IDX_BAUD_DIVISOR) begin
                s_nxt.divisor = pwdata_i[7:0];
            end else if (idx == IDX_DATA_BUFFER) begin
                s_nxt.tx_buf = pwdata_i[7:0];
            end
        end
        // Read side effects
        if (bus_rd && idx == IDX_DATA_BUFFER) begin
            s_nxt.receive_full_flag = 1'b0;
        end else if (bus_rd && idx == IDX_LINE_STATUS) begin
            s_nxt.parity_error_flag = 1'b0;
            s_nxt.framing_error_flag = 1'b0;
            s_nxt.overrun_flag = 1'b0;
        end
        // Transmit full clears after interrupt pulse
        if (s_r.irq) begin
            s_nxt.transmit_full_flag = 1'b0;
        end
        if (cfg_wr && idx == IDX_DATA_BUFFER) begin
            s_nxt.transmit_full_flag = 1'b1;
        end
        // Frame events only with port clock running
        if (port_on) begin
            if (rx_start_i && s_r.ctl_one[CR1_RX_EN]) begin
                s_nxt.rbsy = 1'b1;
            end
            if (rx_done_i && s_r.rbsy) begin
                s_nxt.rbsy   = 1'b0;
                s_nxt.rx_buf = rx_byte_i;
                s_nxt.receive_full_flag   = 1'b1;
                if (rx_parity_err_i) begin
                    s_nxt.parity_error_flag = 1'b1;
                end
                if (rx_frame_err_i) begin
                    s_nxt.framing_error_flag = 1'b1;
                end
                if (s_r.receive_full_flag && !(bus_rd && idx == IDX_DATA_BUFFER)) begin
                    s_nxt.overrun_flag = 1'b1;
                end
            end
            // Transmit busy from load to done
            if (s_r.ctl_one[CR1_TX_EN] && s_r.transmit_full_flag && !s_r.tbsy && !s_r.irq) begin
                s_nxt.tx_load = 1'b1;
                s_nxt.tx_dat  = s_r.tx_buf;
                s_nxt.tbsy    = 1'b1;
                s_nxt.irq     = 1'b1;
            end else if (tx_done_i && s_r.tbsy) begin
                s_nxt.tbsy = 1'b0;
            end
            if (s_r.ctl_one[CR1_BASE_SEL]) begin
                s_nxt.cnt  = 8'h00;
                s_nxt.tick = tmr_rise;
            end else if (s_r.cnt >= s_r.divisor) begin
                s_nxt.cnt  = 8'h00;
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.cnt = 8'(s_r.cnt + 8'h01);
            end
        end else begin
            s_nxt.cnt = 8'h00;
        end
        // Low-power entry stops the port
        if (lp_entry) begin
            s_nxt.ctl_one[CR1_TX_EN] = 1'b0;
            s_nxt.ctl_one[CR1_RX_EN] = 1'b0;
            s_nxt.parity_error_flag    = 1'b0;
            s_nxt.framing_error_flag    = 1'b0;
            s_nxt.overrun_flag    = 1'b0;
            s_nxt.rbsy    = 1'b0;
            s_nxt.receive_full_flag    = 1'b0;
            s_nxt.tbsy    = 1'b0;
            s_nxt.transmit_full_flag    = 1'b0;
            s_nxt.rx_buf  = RST_DATA_BUFFER;
            s_nxt.tx_buf  = RST_DATA_BUFFER;
            s_nxt.tx_load = 1'b0;
            s_nxt.irq     = 1'b0;
            s_nxt.tick    = 1'b0;
            s_nxt.divisor = s_r.divisor;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r         <= '0;
            s_r.ctl_one <= RST_CONTROL_ONE;
            s_r.ctl_two <= RST_CONTROL_TWO;
            s_r.divisor <= RST_BAUD_DIVISOR;
            s_r.gate    <= RST_GATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign prdata_o                     = s_r.rdata;
    assign pready_o                     = 1'b1;
    assign pslverr_o                    = access & ~hit;
    assign tx_load_o                    = s_r.tx_load;
    assign tx_data_o                    = s_r.tx_dat;
    assign transmit_interrupt_request_o = s_r.irq;
    assign port_clock_enable_o          = port_on;
    assign base_tick_o                  = s_r.tick;
    assign tx_enable_o                  = s_r.ctl_one[CR1_TX_EN];
    assign rx_enable_o                  = s_r.ctl_one[CR1_RX_EN];
    assign tx_two_stop_o                = s_r.ctl_one[CR1_TX_STOP];
    assign parity_even_o                = s_r.ctl_one[CR1_PAR_EVEN];
    assign parity_enable_o              = s_r.ctl_one[CR1_PAR_EN];
    assign ir_select_o                  = s_r.ctl_one[CR1_IR_SEL];
    assign rt_select_o                  = s_r.ctl_two[CR2_RT_LSB+:3];
    assign noise_select_o               = s_r.ctl_two[CR2_NOISE_LSB+:2];
    assign rx_two_stop_o                = s_r.ctl_two[CR2_RX_STOP];

    // Checks on the register logic
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_status_bit_four: assert property (setup && idx == IDX_LINE_STATUS |=> s_r.rdata[7:4] ==
        $past({s_r.parity_error_flag, s_r.framing_error_flag, s_r.overrun_flag, 1'b0})) else $error("status read bits 7..4 wrong");
    a_lp_keeps_divisor: assert property (lp_entry |=> s_r.divisor == $past(s_r.divisor))
        else $error("divisor changed on low power entry");
    a_lp_clears_status: assert property (lp_entry |=> pack_status(s_r) == 8'h00)
        else $error("status not cleared on low power entry");
    a_lp_enables_off: assert property (lp_entry |=> s_r.ctl_one[7:6] == 2'h0
        && s_r.ctl_one[5:1] == $past(s_r.ctl_one[5:1])) else $error("low power control update wrong");
    a_tx_full_set: assert property (cfg_wr && idx == IDX_DATA_BUFFER && !lp_entry |=> s_r.transmit_full_flag)
        else $error("transmit full not set by write");
    a_tx_full_clear: assert property (s_r.irq && !(cfg_wr && idx == IDX_DATA_BUFFER) |=> !s_r.transmit_full_flag)
        else $error("transmit full not cleared after interrupt");
    a_tx_lock_hold: assert property (cfg_wr && idx == IDX_CONTROL_ONE && !tx_unlock && !lp_entry
        |=> {s_r.ctl_one[5], s_r.ctl_one[2]} == $past({s_r.ctl_one[5], s_r.ctl_one[2]}))
        else $error("transmit protected bit changed");
    a_all_lock_hold: assert property (cfg_wr && idx == IDX_CONTROL_TWO && !all_unlock
        |=> s_r.ctl_two[5:3] == $past(s_r.ctl_two[5:3])) else $error("count select changed while busy");
    a_rx_lock_hold: assert property (cfg_wr && idx == IDX_CONTROL_TWO && !rx_unlock
        |=> s_r.ctl_two[2:0] == $past(s_r.ctl_two[2:0])) else $error("receive protected bit changed");
    a_timer_no_div: assert property (s_r.ctl_one[CR1_BASE_SEL] && !tmr_rise |=> !s_r.tick)
        else $error("tick produced without timer edge");
    a_gate_stops_rx: assert property (!s_r.gate && !s_r.rbsy |=> !s_r.rbsy)
        else $error("receive started with gate off");
    a_rx_byte_kept: assert property (port_on && rx_done_i && s_r.rbsy && !lp_entry
        |=> s_r.receive_full_flag && s_r.rx_buf == $past(rx_byte_i)) else $error("received byte not stored");
    a_tx_busy_load: assert property (s_r.tx_load |-> s_r.tbsy [*1] ##1 s_r.tbsy || lp_entry)
        else $error("transmit busy not set at load");

    c_tx_load: cover property (s_r.tx_load ##[1:20] tx_done_i);
    c_overrun: cover property (s_r.receive_full_flag ##1 s_r.overrun_flag);
    c_lp_entry: cover property (s_r.tbsy && lp_entry);
endmodule

/* File: verification/serial_line_model.sv */
// Purpose: Remote serial peer as frame events and a transmit handshake.
// Assumes: Bench pulses send_i for one cycle per frame to be received.
// Notes:   Byte lines invert every cycle outside the done pulse.
`timescale 1ns/10ps
module serial_line_model #(
    parameter int DLY = 8
) (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    // Bench frame request
    input  wire logic       send_i,
    input  wire logic [7:0] byte_i,
    input  wire logic [1:0] err_i,
    // Receive events
    output logic            rx_start_o,
    output logic            rx_done_o,
    output logic      [7:0] rx_byte_o,
    output logic            rx_parity_err_o,
    output logic            rx_frame_err_o,
    // Transmit handshake
    input  wire logic       tx_load_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_done_o,
    output logic      [7:0] sent_o
);
    int rc; // Receive frame countdown
    int tc; // Transmit frame countdown
    // Frame timing for both directions
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {rx_start_o, rx_done_o, rx_byte_o, rx_parity_err_o, rx_frame_err_o, tx_done_o, sent_o} <= '0;
            rc <= 0;
            tc <= 0;
        end else begin
            rx_start_o <= send_i;
            rx_done_o <= (rc == 1);
            rx_byte_o <= (rc == 1) ? byte_i : ~rx_byte_o;
            rx_parity_err_o <= (rc == 1) & err_i[0];
            rx_frame_err_o <= (rc == 1) & err_i[1];
            rc <= send_i ? DLY : (rc > 0 ? rc - 1 : 0);
            tx_done_o <= (tc == 1);
            tc <= tx_load_i ? DLY : (tc > 0 ? tc - 1 : 0);
            if (tx_load_i) sent_o <= tx_data_i;
        end
    end
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the serial port register block.
// Assumes: Zero-wait APB slave; line model answers after DLY cycles.
// Notes:   Byte address is four times the word index.
`timescale 1ns/10ps
module tb;
    import serial_regs_pkg::*;
    localparam int DLY = 8;
    logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic        low_power = 0, timer = 0, send = 0, err_s;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic        pready, pslverr, rx_start, rx_done, parity_error_flag, framing_error_flag, tx_done, tx_load, irq, gate_en, tick;
    logic [7:0]  rx_byte, tx_data, sent, byte_v = 0;
    logic [1:0]  err_v = 0;
    logic [7:2]  cfg;
    logic [5:0]  cfg2;
    int          failures = 0, total_checks = 0, ticks = 0, loads = 0, t0;
    always #12.5 clk = ~clk;
    serial_port_regs i_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .low_power_i(low_power), .timer_output_clock_i(timer), .rx_start_i(rx_start),
        .rx_done_i(rx_done), .rx_byte_i(rx_byte), .rx_parity_err_i(parity_error_flag), .rx_frame_err_i(framing_error_flag),
        .tx_done_i(tx_done), .tx_load_o(tx_load), .tx_data_o(tx_data), .transmit_interrupt_request_o(irq),
        .port_clock_enable_o(gate_en), .base_tick_o(tick), .tx_enable_o(cfg[7]), .rx_enable_o(cfg[6]),
        .tx_two_stop_o(cfg[5]), .parity_even_o(cfg[4]), .parity_enable_o(cfg[3]), .ir_select_o(cfg[2]),
        .rt_select_o(cfg2[5:3]), .noise_select_o(cfg2[2:1]), .rx_two_stop_o(cfg2[0]));
    serial_line_model #(.DLY(DLY)) i_line (.sys_clk_i(clk), .rst_b_i(rst_b), .send_i(send), .byte_i(byte_v),
        .err_i(err_v), .rx_start_o(rx_start), .rx_done_o(rx_done), .rx_byte_o(rx_byte),
        .rx_parity_err_o(parity_error_flag), .rx_frame_err_o(framing_error_flag), .tx_load_i(tx_load), .tx_data_i(tx_data),
        .tx_done_o(tx_done), .sent_o(sent));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err_s = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1, idx, d);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(0, idx, 0);
        check(rd, exp);
    endtask
    // Ask the peer for one frame
    task automatic frame(input logic [7:0] b, input logic [1:0] e);
        send <= 1;
        byte_v <= b;
        err_v <= e;
        @(posedge clk);
        send <= 0;
        repeat (2) @(posedge clk);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Event counters and pulse pairing, sampled mid-cycle where pulses are settled
    always @(negedge clk) begin
        if (tick === 1'b1) ticks++;
        if (tx_load === 1'b1) loads++;
        if (tx_load === 1'b1) check(32'(irq), 1);
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        rdc(IDX_LINE_STATUS, 0);
        rdc(IDX_POWER_OFF, 0);
        check(32'(gate_en), 0);
        wr(IDX_BAUD_DIVISOR, 8'h03);
        rdc(IDX_BAUD_DIVISOR, 0);
        apb(0, 8'h20, 0);
        check(32'(err_s), 1);
        $display("test reset done");
        wr(IDX_POWER_OFF, 1); // gate stays on through every transfer below
        check(32'(gate_en), 1);
        wr(IDX_BAUD_DIVISOR, 8'h03);
        t0 = ticks;
        repeat (40) @(posedge clk);
        check(ticks - t0, 10);
        wr(IDX_CONTROL_ONE, 8'h02);
        t0 = ticks;
        repeat (40) @(posedge clk);
        check(ticks - t0, 0);
        repeat (3) begin
            timer <= 1;
            repeat (4) @(posedge clk);
            timer <= 0;
            repeat (4) @(posedge clk);
        end
        check(ticks - t0, 3);
        $display("test clock source done");
        wr(IDX_CONTROL_ONE, 8'h40);
        frame(8'ha5, 2'b11);
        rdc(IDX_LINE_STATUS, 8'h08);
        repeat (DLY) @(posedge clk);
        rdc(IDX_LINE_STATUS, 8'hc4);
        rdc(IDX_LINE_STATUS, 8'h04);
        rdc(IDX_DATA_BUFFER, 8'ha5);
        rdc(IDX_LINE_STATUS, 8'h00);
        frame(8'h11, 2'b00);
        repeat (DLY) @(posedge clk);
        frame(8'h22, 2'b00);
        repeat (DLY) @(posedge clk);
        rdc(IDX_LINE_STATUS, 8'h24);
        rdc(IDX_DATA_BUFFER, 8'h22);
        $display("test receive done");
        wr(IDX_DATA_BUFFER, 8'h3c);
        rdc(IDX_LINE_STATUS, 8'h01);
        wr(IDX_CONTROL_ONE, 8'hc0);
        repeat (2) @(posedge clk);
        rdc(IDX_LINE_STATUS, 8'h02);
        repeat (DLY) @(posedge clk);
        check(32'(sent), 8'h3c);
        rdc(IDX_LINE_STATUS, 8'h00);
        $display("test transmit done");
        wr(IDX_CONTROL_ONE, 8'hfe);
        rdc(IDX_CONTROL_ONE, 8'hc0);
        wr(IDX_CONTROL_ONE, 8'h40);
        wr(IDX_CONTROL_ONE, 8'h7e);
        rdc(IDX_CONTROL_ONE, 8'h64);
        wr(IDX_CONTROL_TWO, 8'h3f);
        rdc(IDX_CONTROL_TWO, 8'h00);
        wr(IDX_CONTROL_ONE, 8'h00);
        wr(IDX_CONTROL_TWO, 8'hff);
        rdc(IDX_CONTROL_TWO, 8'h3f);
        check(32'(cfg2), 8'h3f);
        wr(IDX_CONTROL_ONE, 8'hdf);
        rdc(IDX_CONTROL_ONE, 8'hde);
        check(32'(cfg), 8'h37);
        $display("test protection done");
        frame(8'h77, 2'b00);
        repeat (DLY) @(posedge clk);
        low_power <= 1;
        repeat (4) @(posedge clk);
        low_power <= 0;
        @(posedge clk);
        rdc(IDX_CONTROL_ONE, 8'h1e);
        rdc(IDX_LINE_STATUS, 8'h00);
        rdc(IDX_DATA_BUFFER, 8'h00);
        rdc(IDX_BAUD_DIVISOR, 8'h03);
        t0 = loads;
        wr(IDX_CONTROL_ONE, 8'h80);
        repeat (6) @(posedge clk);
        check(loads - t0, 0);
        $display("test low power done");
        conclude();
    end
endmodule
